// ### logic/teliam_defs.vh
// Purpose: Constants for the telephone heading and initial address message codec
// Assumes: Included by every file of the codec by bare name
// Notes:   Bit positions count in send order; each field goes LSB first
`ifndef TELIAM_DEFS_VH
`define TELIAM_DEFS_VH

// Register byte offsets
`define TELIAM_REG_CTRL      6'h00
`define TELIAM_REG_TX_LBL_LO 6'h04
`define TELIAM_REG_TX_LBL_HI 6'h08
`define TELIAM_REG_TX_IAM    6'h0c
`define TELIAM_REG_TX_DIG_LO 6'h10
`define TELIAM_REG_TX_DIG_HI 6'h14
`define TELIAM_REG_STATUS    6'h18
`define TELIAM_REG_RX_HEAD   6'h1c
`define TELIAM_REG_RX_LBL_LO 6'h20
`define TELIAM_REG_RX_LBL_HI 6'h24
`define TELIAM_REG_RX_IAM    6'h28
`define TELIAM_REG_RX_DIG_LO 6'h2c
`define TELIAM_REG_RX_DIG_HI 6'h30

// Frame field positions
`define TELIAM_POS_LBL   0
`define TELIAM_POS_H0    40
`define TELIAM_POS_H1    44
`define TELIAM_POS_CAT   48
`define TELIAM_POS_SPARE 54
`define TELIAM_POS_IND   56
`define TELIAM_POS_CNT   68
`define TELIAM_POS_DIG   72
`define TELIAM_FRM_W     136
`define TELIAM_HDR_LEN   8'h30
`define TELIAM_IAM_FIX   8'h48

// Heading codes
`define TELIAM_H0_FAM 4'h1
`define TELIAM_H0_FSM 4'h2
`define TELIAM_H0_BSM 4'h3
`define TELIAM_H0_SBM 4'h4
`define TELIAM_H0_UBM 4'h5
`define TELIAM_H0_CSM 4'h6
`define TELIAM_H0_CCM 4'h7
`define TELIAM_H1_IAM 4'h1
`define TELIAM_H1_EXT 4'hf

// Calling party category classes
`define TELIAM_CAT_SPARE  3'h0
`define TELIAM_CAT_OPLANG 3'h1
`define TELIAM_CAT_ADLANG 3'h2
`define TELIAM_CAT_NATOP  3'h3
`define TELIAM_CAT_ORD    3'h4
`define TELIAM_CAT_PRIO   3'h5
`define TELIAM_CAT_DATA   3'h6
`define TELIAM_CAT_TEST   3'h7

// Reset values
`define TELIAM_RST_H      4'h1
`define TELIAM_RST_CAT    6'h0a
`define TELIAM_RST_WORD   32'h00000000

`endif

// ### logic/teliam_hclass.v
// Purpose: Classifies a heading pair into message group and recognition
// Assumes: Pure combinational, used for both send and receive
// Notes:   Group 0 means no allocated group
`timescale 1ns/10ps
`default_nettype none
`include "teliam_defs.vh"
module teliam_hclass (
  // Heading
  input  wire [3:0] i_h0,
  input  wire [3:0] i_h1,
  // Result
  output reg  [2:0] o_group,
  output reg        o_known,
  output wire       o_nat_rsv,
  output wire       o_intl_rsv
);
  reg [3:0] top;

  assign o_nat_rsv  = (i_h0 == 4'h0) || (i_h0[3:2] == 2'b11);
  assign o_intl_rsv = (i_h0[3:2] == 2'b10);

  always @* begin
    top     = 4'h0;
    o_group = 3'h0;
    if (i_h0 >= `TELIAM_H0_FAM && i_h0 <= `TELIAM_H0_CCM) begin
      o_group = i_h0[2:0];
    end
    case (i_h0)
      `TELIAM_H0_FAM: top = 4'h4;
      `TELIAM_H0_FSM: top = 4'h4;
      `TELIAM_H0_BSM: top = 4'h1;
      `TELIAM_H0_SBM: top = 4'h2;
      `TELIAM_H0_UBM: top = 4'h9;
      `TELIAM_H0_CSM: top = 4'h6;
      `TELIAM_H0_CCM: top = 4'h7;
      default:        top = 4'h0;
    endcase
    o_known = (o_group != 3'h0) && (i_h1 != 4'h0) && (i_h1 <= top);
    if ((i_h0 == `TELIAM_H0_UBM || i_h0 == `TELIAM_H0_CSM) && i_h1 == `TELIAM_H1_EXT) begin
      o_known = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### logic/teliam_catdec.v
// Purpose: Decodes calling party category and flags spare indicator codes
// Assumes: Pure combinational
// Notes:   Spare or national codes are reported, not rejected
`timescale 1ns/10ps
`default_nettype none
`include "teliam_defs.vh"
module teliam_catdec (
  // Fields
  input  wire [5:0] i_cat,
  input  wire [6:0] i_ind,
  // Result
  output reg  [2:0] o_class,
  output wire       o_ind_spare
);
  // Nature of address 01 national, satellite 1x spare, continuity 11 spare
  assign o_ind_spare = (i_ind[1:0] == 2'b01) || i_ind[3] || (i_ind[5:4] == 2'b11);

  always @* begin
    case (i_cat)
      6'h01, 6'h02, 6'h03, 6'h04, 6'h05: o_class = `TELIAM_CAT_OPLANG;
      6'h06, 6'h07, 6'h08:               o_class = `TELIAM_CAT_ADLANG;
      6'h09:                             o_class = `TELIAM_CAT_NATOP;
      6'h0a:                             o_class = `TELIAM_CAT_ORD;
      6'h0b:                             o_class = `TELIAM_CAT_PRIO;
      6'h0c:                             o_class = `TELIAM_CAT_DATA;
      6'h0d:                             o_class = `TELIAM_CAT_TEST;
      default:                           o_class = `TELIAM_CAT_SPARE;
    endcase
  end
endmodule
`default_nettype wire

// ### logic/teliam_codec.v
// Purpose: Builds and parses telephone signalling messages and the initial address message
// Assumes: Serial link logic on i_clk; Avalon-MM slave with waitrequest for software
// Notes:   Whole frames are held in flip-flops, one bit per index
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "teliam_defs.vh"
module teliam_codec (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_ce,
  // Avalon-MM slave
  input  wire [5:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // Transmit bit stream
  output reg         o_tx_valid,
  output reg         o_tx_bit,
  output reg         o_tx_last,
  input  wire        i_tx_ready,
  // Receive bit stream
  input  wire        i_rx_valid,
  input  wire        i_rx_bit,
  input  wire        i_rx_last
);
  localparam FW = `TELIAM_FRM_W;

  // Software registers
  reg [39:0]   tx_lbl;
  reg [3:0]    tx_h0;
  reg [3:0]    tx_h1;
  reg [5:0]    tx_cat;
  reg [6:0]    tx_ind;
  reg [3:0]    tx_cnt;
  reg [63:0]   tx_dig;
  reg          acked;
  reg          tx_refused;
  reg          rx_done;
  // Transmit state
  reg [FW-1:0] tx_buf;
  reg [7:0]    tx_pos;
  reg [7:0]    tx_len;
  // Receive state
  reg [FW-1:0] rx_buf;
  reg [7:0]    rx_pos;
  reg          rx_eval;
  reg [7:0]    rx_len;
  reg [39:0]   rx_lbl;
  reg [3:0]    rx_h0;
  reg [3:0]    rx_h1;
  reg [5:0]    rx_cat;
  reg [6:0]    rx_ind;
  reg [3:0]    rx_cnt;
  reg [63:0]   rx_dig;
  reg          rx_unrec;
  reg          rx_len_err;
  reg          rx_bad_dig;
  reg          rx_is_iam;
  reg          rx_ind_spare;
  reg [2:0]    rx_cls;
  // Combinational
  reg [FW-1:0] next_frame;
  reg [7:0]    next_len;
  reg [63:0]   next_dig;
  reg          next_bad;
  integer      k;
  integer      j;

  wire       acc       = (i_avs_read || i_avs_write) && !acked;
  wire       wr_go     = i_avs_write && acked && i_ce;
  wire       tx_busy   = o_tx_valid;
  wire       tx_start  = wr_go && (i_avs_address == `TELIAM_REG_CTRL) && i_avs_writedata[0];
  wire       tx_iam    = (tx_h0 == `TELIAM_H0_FAM) && (tx_h1 == `TELIAM_H1_IAM);
  wire       tx_known;
  wire       rx_known;
  wire [2:0] rx_group;
  wire [2:0] rx_cls_w;
  wire       rx_spare_w;
  wire [3:0] rx_h0_w   = rx_buf[`TELIAM_POS_H0 +: 4];
  wire [3:0] rx_h1_w   = rx_buf[`TELIAM_POS_H1 +: 4];
  wire [3:0] rx_cnt_w  = rx_buf[`TELIAM_POS_CNT +: 4];
  wire       rx_iam_w  = (rx_h0_w == `TELIAM_H0_FAM) && (rx_h1_w == `TELIAM_H1_IAM);

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !acked;

  // Address signal codes 1010, 1101 and 1110 are spare
  function dig_ok;
    input [3:0] d;
    begin
      dig_ok = (d <= 4'h9) || (d == 4'hb) || (d == 4'hc) || (d == 4'hf);
    end
  endfunction

  // Address field rounds up to whole octets, filler included
  function [7:0] iam_len;
    input [3:0] n;
    begin
      iam_len = `TELIAM_IAM_FIX + {1'b0, {1'b0, n[3:1]} + {3'h0, n[0]}, 3'h0};
    end
  endfunction

  teliam_hclass u_tx_class (
    .i_h0       (tx_h0),
    .i_h1       (tx_h1),
    .o_group    (),
    .o_known    (tx_known),
    .o_nat_rsv  (),
    .o_intl_rsv ()
  );

  teliam_hclass u_rx_class (
    .i_h0       (rx_h0_w),
    .i_h1       (rx_h1_w),
    .o_group    (rx_group),
    .o_known    (rx_known),
    .o_nat_rsv  (),
    .o_intl_rsv ()
  );

  teliam_catdec u_rx_cat (
    .i_cat       (rx_buf[`TELIAM_POS_CAT +: 6]),
    .i_ind       (rx_buf[`TELIAM_POS_IND +: 7]),
    .o_class     (rx_cls_w),
    .o_ind_spare (rx_spare_w)
  );

  // Frame assembly; every bit not set here is a spare zero
  always @* begin
    next_frame = {FW{1'b0}};
    next_frame[`TELIAM_POS_LBL +: 40] = tx_lbl;
    next_frame[`TELIAM_POS_H0 +: 4] = tx_h0;
    next_frame[`TELIAM_POS_H1 +: 4] = tx_h1;
    next_len = `TELIAM_HDR_LEN;
    if (tx_iam) begin
      next_frame[`TELIAM_POS_CAT +: 6] = tx_cat;
      next_frame[`TELIAM_POS_IND +: 7] = tx_ind;
      next_frame[`TELIAM_POS_CNT +: 4] = tx_cnt;
      for (k = 0; k < 16; k = k + 1) begin
        if (k < tx_cnt) begin
          next_frame[`TELIAM_POS_DIG + 4*k +: 4] = tx_dig[4*k +: 4];
        end
      end
      next_len = iam_len(tx_cnt);
    end
  end

  // Received address digits; the filler past the count is dropped
  always @* begin
    next_dig = 64'h0;
    next_bad = 1'b0;
    for (j = 0; j < 16; j = j + 1) begin
      if (j < rx_cnt_w) begin
        next_dig[4*j +: 4] = rx_buf[`TELIAM_POS_DIG + 4*j +: 4];
        if (!dig_ok(rx_buf[`TELIAM_POS_DIG + 4*j +: 4])) begin
          next_bad = 1'b1;
        end
      end
    end
  end

  // Bus slave: one wait cycle, then the access completes
  always @(posedge i_clk) begin
    if (i_reset) begin
      acked          <= 1'b0;
      o_avs_readdata <= `TELIAM_RST_WORD;
    end else if (i_ce) begin
      acked <= acc;
      if (acc && i_avs_read) begin
        case (i_avs_address)
          `TELIAM_REG_CTRL:      o_avs_readdata <= {20'h0, tx_h1, tx_h0, 3'h0, tx_busy};
          `TELIAM_REG_TX_LBL_LO: o_avs_readdata <= tx_lbl[31:0];
          `TELIAM_REG_TX_LBL_HI: o_avs_readdata <= {24'h0, tx_lbl[39:32]};
          `TELIAM_REG_TX_IAM:    o_avs_readdata <= {12'h0, tx_cnt, 1'b0, tx_ind, 2'h0, tx_cat};
          `TELIAM_REG_TX_DIG_LO: o_avs_readdata <= tx_dig[31:0];
          `TELIAM_REG_TX_DIG_HI: o_avs_readdata <= tx_dig[63:32];
          `TELIAM_REG_STATUS:    o_avs_readdata <= {24'h0, rx_ind_spare, rx_is_iam, rx_bad_dig,
                                                    rx_len_err, rx_unrec, rx_done, tx_refused,
                                                    tx_busy};
          `TELIAM_REG_RX_HEAD:   o_avs_readdata <= {21'h0, rx_cls, rx_h1, rx_h0};
          `TELIAM_REG_RX_LBL_LO: o_avs_readdata <= rx_lbl[31:0];
          `TELIAM_REG_RX_LBL_HI: o_avs_readdata <= {24'h0, rx_lbl[39:32]};
          `TELIAM_REG_RX_IAM:    o_avs_readdata <= {12'h0, rx_cnt, 1'b0, rx_ind, 2'h0, rx_cat};
          `TELIAM_REG_RX_DIG_LO: o_avs_readdata <= rx_dig[31:0];
          `TELIAM_REG_RX_DIG_HI: o_avs_readdata <= rx_dig[63:32];
          default:               o_avs_readdata <= `TELIAM_RST_WORD;
        endcase
      end
    end
  end

  // Transmit configuration; writes while busy only touch the next frame
  always @(posedge i_clk) begin
    if (i_reset) begin
      tx_lbl <= 40'h0;
      tx_h0  <= `TELIAM_RST_H;
      tx_h1  <= `TELIAM_RST_H;
      tx_cat <= `TELIAM_RST_CAT;
      tx_ind <= 7'h0;
      tx_cnt <= 4'h0;
      tx_dig <= 64'h0;
    end else if (wr_go) begin
      case (i_avs_address)
        `TELIAM_REG_CTRL: begin
          tx_h0 <= i_avs_writedata[7:4];
          tx_h1 <= i_avs_writedata[11:8];
        end
        `TELIAM_REG_TX_LBL_LO: tx_lbl[31:0] <= i_avs_writedata;
        `TELIAM_REG_TX_LBL_HI: tx_lbl[39:32] <= i_avs_writedata[7:0];
        `TELIAM_REG_TX_IAM: begin
          tx_cat <= i_avs_writedata[5:0];
          tx_ind <= i_avs_writedata[14:8];
          tx_cnt <= i_avs_writedata[19:16];
        end
        `TELIAM_REG_TX_DIG_LO: tx_dig[31:0] <= i_avs_writedata;
        `TELIAM_REG_TX_DIG_HI: tx_dig[63:32] <= i_avs_writedata;
        default: tx_cnt <= tx_cnt;
      endcase
    end
  end

  // Transmit serialiser; start uses the heading already stored
  always @(posedge i_clk) begin
    if (i_reset) begin
      tx_buf     <= {FW{1'b0}};
      tx_pos     <= 8'h0;
      tx_len     <= 8'h0;
      o_tx_valid <= 1'b0;
      o_tx_bit   <= 1'b0;
      o_tx_last  <= 1'b0;
      tx_refused <= 1'b0;
    end else if (i_ce) begin
      if (wr_go && i_avs_address == `TELIAM_REG_STATUS && i_avs_writedata[1]) begin
        tx_refused <= 1'b0;
      end
      if (tx_start && !tx_busy) begin
        if (!tx_known) begin
          tx_refused <= 1'b1;
        end else begin
          tx_buf     <= next_frame;
          tx_len     <= next_len;
          tx_pos     <= 8'h0;
          o_tx_valid <= 1'b1;
          o_tx_bit   <= next_frame[0];
          o_tx_last  <= 1'b0;
        end
      end else if (o_tx_valid && i_tx_ready) begin
        if (o_tx_last) begin
          o_tx_valid <= 1'b0;
          o_tx_last  <= 1'b0;
        end else begin
          tx_pos    <= tx_pos + 8'h1;
          o_tx_bit  <= tx_buf[tx_pos + 8'h1];
          o_tx_last <= (tx_pos + 8'h2 == tx_len);
        end
      end
    end
  end

  // Receive collector and parser
  always @(posedge i_clk) begin
    if (i_reset) begin
      rx_buf       <= {FW{1'b0}};
      rx_pos       <= 8'h0;
      rx_eval      <= 1'b0;
      rx_len       <= 8'h0;
      rx_done      <= 1'b0;
      rx_lbl       <= 40'h0;
      rx_h0        <= 4'h0;
      rx_h1        <= 4'h0;
      rx_cat       <= 6'h0;
      rx_ind       <= 7'h0;
      rx_cnt       <= 4'h0;
      rx_dig       <= 64'h0;
      rx_unrec     <= 1'b0;
      rx_len_err   <= 1'b0;
      rx_bad_dig   <= 1'b0;
      rx_is_iam    <= 1'b0;
      rx_ind_spare <= 1'b0;
      rx_cls       <= 3'h0;
    end else if (i_ce) begin
      rx_eval <= 1'b0;
      if (wr_go && i_avs_address == `TELIAM_REG_STATUS && i_avs_writedata[2]) begin
        rx_done <= 1'b0;
      end
      if (i_rx_valid) begin
        if (rx_pos < FW) begin
          rx_buf[rx_pos] <= i_rx_bit;
        end
        if (i_rx_last) begin
          rx_len  <= (rx_pos == 8'hff) ? rx_pos : rx_pos + 8'h1;
          rx_pos  <= 8'h0;
          rx_eval <= 1'b1;
        end else if (rx_pos != 8'hff) begin
          rx_pos <= rx_pos + 8'h1;
        end
      end
      if (rx_eval) begin
        rx_done   <= 1'b1;
        rx_lbl    <= rx_buf[`TELIAM_POS_LBL +: 40];
        rx_h0     <= rx_h0_w;
        rx_h1     <= rx_h1_w;
        rx_is_iam <= 1'b0;
        rx_unrec  <= !rx_known || (rx_len < `TELIAM_HDR_LEN) || (rx_group == 3'h0);
        rx_len_err <= (rx_len < `TELIAM_HDR_LEN) ||
                      (rx_iam_w && (rx_len != iam_len(rx_cnt_w)));
        rx_bad_dig <= 1'b0;
        rx_ind_spare <= 1'b0;
        if (rx_known && rx_iam_w && rx_len == iam_len(rx_cnt_w)) begin
          rx_is_iam    <= 1'b1;
          rx_cat       <= rx_buf[`TELIAM_POS_CAT +: 6];
          rx_cls       <= rx_cls_w;
          rx_ind       <= rx_buf[`TELIAM_POS_IND +: 7];
          rx_ind_spare <= rx_spare_w;
          rx_cnt       <= rx_cnt_w;
          rx_dig       <= next_dig;
          rx_bad_dig   <= next_bad;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### test/teliam_codec_chk.sv
// Purpose: Concurrent checks on the codec transmit stream
// Assumes: Bound to teliam_codec; one clock domain
// Notes:   A bit counter follows every accepted bit of a frame
`timescale 1ns/10ps
`default_nettype none
module teliam_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Transmit stream
  input wire logic o_tx_valid,
  input wire logic o_tx_bit,
  input wire logic o_tx_last,
  input wire logic i_tx_ready
);
  logic [7:0]   idx;
  logic [135:0] f;
  wire          acc = o_tx_valid & i_tx_ready & i_ce;
  wire  [3:0]   h1  = {o_tx_bit, f[46:44]};

  always @(posedge i_clk) begin
    if (i_reset) begin
      idx <= 8'h00;
    end else if (acc) begin
      f[idx] <= o_tx_bit;
      idx    <= o_tx_last ? 8'h00 : idx + 8'h01;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_stall;
    o_tx_valid && !i_tx_ready;
  endsequence
  sequence s_take;
    acc && o_tx_last;
  endsequence

  bit_hold_a: assert property (s_stall |=> o_tx_valid && $stable(o_tx_bit) && $stable(o_tx_last))
    else $error("tx bit changed while stalled");
  last_drop_a: assert property (s_take |=> !o_tx_valid)
    else $error("tx valid stayed after last bit");
  head_len_a: assert property (acc && idx == 8'd47 |-> o_tx_last == ({h1, f[43:40]} != 8'h11))
    else $error("heading length wrong for message type");
  group_ok_a: assert property (acc && idx == 8'd44 |-> f[43:40] inside {[4'h1:4'h7]})
    else $error("reserved group heading generated");
  fam_type_a: assert property (acc && idx == 8'd47 && f[43:40] == 4'h1 |-> h1 inside {[4'h1:4'h4]})
    else $error("bad forward address type");
  ubm_type_a: assert property (acc && idx == 8'd47 && f[43:40] == 4'h5 |-> h1 inside {[4'h1:4'h9], 4'hf})
    else $error("bad unsuccessful backward type");
  spare_zero_a: assert property (acc && idx inside {8'd54, 8'd55, [8'd63:8'd67]} |-> !o_tx_bit)
    else $error("spare bit sent as one");
  iam_len_a: assert property ((s_take and idx > 8'd47) |-> idx == 71 + 8 * ((f[71:68] + 5'd1) / 2))
    else $error("address length does not match count");
  filler_a: assert property (acc && idx >= 72 + 4 * f[71:68] && f[68] |-> !o_tx_bit)
    else $error("filler not zero");
endmodule

bind teliam_codec teliam_chk i_chk (
  .i_clk      (i_clk),
  .i_reset    (i_reset),
  .i_ce       (i_ce),
  .o_tx_valid (o_tx_valid),
  .o_tx_bit   (o_tx_bit),
  .o_tx_last  (o_tx_last),
  .i_tx_ready (i_tx_ready)
);
`default_nettype wire

// ### test/teliam_peer.sv
// Purpose: Peer exchange model: sinks transmitted frames and echoes them back
// Assumes: Same clock as the codec
// Notes:   Slow mode accepts every other cycle; corrupt flips the top H0 bit
`timescale 1ns/10ps
`default_nettype none
module teliam_peer (
  // Clock and control
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic         i_slow,
  input  wire logic         i_corrupt,
  // From the codec
  input  wire logic         i_tx_valid,
  input  wire logic         i_tx_bit,
  input  wire logic         i_tx_last,
  output logic              o_tx_ready,
  // To the codec
  output logic              o_rx_valid,
  output logic              o_rx_bit,
  output logic              o_rx_last,
  // Captured frame
  output logic [135:0]      o_frame,
  output logic [7:0]        o_len
);
  logic [7:0] n;
  logic [7:0] k;
  logic       echo;
  logic       tog;

  assign o_tx_ready = !i_slow || tog;

  always @(posedge i_clk) begin
    if (i_reset) begin
      {tog, echo, o_rx_valid, o_rx_last, o_rx_bit} <= 5'h00;
      {n, k, o_len} <= 24'h000000;
    end else begin
      tog        <= ~tog;
      o_rx_valid <= 1'b0;
      o_rx_last  <= 1'b0;
      // Idle data line keeps changing so a stale bit is never mistaken for data
      o_rx_bit   <= ~o_rx_bit;
      if (i_tx_valid && o_tx_ready) begin
        o_frame[n] <= i_tx_bit;
        n          <= i_tx_last ? 8'h00 : n + 8'h01;
        if (i_tx_last) begin
          o_len <= n + 8'h01;
          echo  <= 1'b1;
          k     <= 8'h00;
        end
      end
      if (echo) begin
        o_rx_valid <= 1'b1;
        o_rx_bit   <= o_frame[k] ^ (i_corrupt && k == 8'd43);
        o_rx_last  <= k + 8'h01 == o_len;
        k          <= k + 8'h01;
        echo       <= k + 8'h01 != o_len;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/test_teliam_codec.sv
// Purpose: Self-checking bench for the heading and address message codec
// Assumes: Peer model echoes each transmitted frame into the receiver
// Notes:   Clock enable is held high throughout
`timescale 1ns/10ps
`default_nettype none
`include "teliam_defs.vh"
module test_teliam_codec;
  logic         clk;
  logic         reset = 1'b1, ce = 1'b1, rd = 1'b0, wr = 1'b0, slow = 1'b0, bad = 1'b0;
  logic [5:0]   adr = 6'h00;
  logic [31:0]  wdat = 32'h0, rdat, q, w;
  logic         wait_req, tx_valid, tx_bit, tx_last, tx_ready, rx_valid, rx_bit, rx_last;
  logic [135:0] frm, e;
  logic [7:0]   len;
  int           n_mismatch = 0, n_tests = 0;
  logic [5:0]   cats[9] = '{6'h00, 6'h01, 6'h06, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e};
  logic [2:0]   cls[9]  = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  logic [7:0]   hd[9]   = '{8'h42, 8'h13, 8'h24, 8'h95, 8'hf5, 8'h66, 8'hf6, 8'h77, 8'h31};
  logic [7:0]   ref_h[6] = '{8'h18, 8'h10, 8'h1c, 8'h76, 8'h23, 8'ha5};

  teliam_codec i_dut (.i_clk(clk), .i_reset(reset), .i_ce(ce), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_req), .o_tx_valid(tx_valid), .o_tx_bit(tx_bit),
    .o_tx_last(tx_last), .i_tx_ready(tx_ready), .i_rx_valid(rx_valid),
    .i_rx_bit(rx_bit), .i_rx_last(rx_last));
  teliam_peer i_peer (.i_clk(clk), .i_reset(reset), .i_slow(slow), .i_corrupt(bad),
    .i_tx_valid(tx_valid), .i_tx_bit(tx_bit), .i_tx_last(tx_last), .o_tx_ready(tx_ready),
    .o_rx_valid(rx_valid), .o_rx_bit(rx_bit), .o_rx_last(rx_last), .o_frame(frm),
    .o_len(len));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [135:0] got, input logic [135:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wn, input logic [5:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    wr   <= wn;
    rd   <= !wn;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      t++;
    end while (wait_req !== 1'b0 && t < 50);
    if (wait_req !== 1'b0) n_mismatch++;
    q  = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(q, x);
  endtask

  // Clears status, stores the heading, starts a frame, polls for echo or refusal
  task automatic send(input logic [3:0] h0, input logic [3:0] h1);
    int t;
    t = 0;
    bus(1'b1, `TELIAM_REG_STATUS, 32'h6);
    bus(1'b1, `TELIAM_REG_CTRL, {20'h0, h1, h0, 4'h0});
    bus(1'b1, `TELIAM_REG_CTRL, {20'h0, h1, h0, 4'h1});
    do begin
      bus(1'b0, `TELIAM_REG_STATUS, 32'h0);
      t++;
    end while (q[2] !== 1'b1 && q[1] !== 1'b1 && t < 300);
    if (q[2] !== 1'b1 && q[1] !== 1'b1) n_mismatch++;
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd_chk(`TELIAM_REG_CTRL, 32'h110);
    rd_chk(`TELIAM_REG_TX_IAM, 32'h0a);
    rd_chk(6'h3c, 32'h0);
    for (int i = 0; i < 9; i++) begin
      w = {22'h0, i[1:0], 2'h0, cats[i]};
      bus(1'b1, `TELIAM_REG_TX_IAM, w);
      send(4'h1, 4'h1);
      rd_chk(`TELIAM_REG_RX_HEAD, {21'h0, cls[i], 8'h11});
      rd_chk(`TELIAM_REG_RX_IAM, w);
      chk(len, 8'd72);
    end
    slow <= 1'b1;
    bus(1'b1, `TELIAM_REG_TX_LBL_LO, 32'h5c3e7b21);
    bus(1'b1, `TELIAM_REG_TX_LBL_HI, 32'h9a);
    bus(1'b1, `TELIAM_REG_TX_IAM, 32'h0003670b);
    bus(1'b1, `TELIAM_REG_TX_DIG_LO, 32'h77777f9b);
    send(4'h1, 4'h1);
    e = {48'h0, 4'h0, 4'hf, 4'h9, 4'hb, 4'h3, 5'h0, 7'h67, 2'h0, 6'h0b, 8'h11, 40'h9a5c3e7b21};
    chk(q, 32'h44);
    chk(len, 8'd88);
    chk(frm & ((136'h1 << len) - 136'h1), e);
    rd_chk(`TELIAM_REG_RX_LBL_LO, 32'h5c3e7b21);
    rd_chk(`TELIAM_REG_RX_LBL_HI, 32'h9a);
    rd_chk(`TELIAM_REG_RX_IAM, 32'h0003670b);
    rd_chk(`TELIAM_REG_RX_DIG_LO, 32'h00000f9b);
    slow <= 1'b0;
    bus(1'b1, `TELIAM_REG_TX_IAM, 32'h00040909);
    bus(1'b1, `TELIAM_REG_TX_DIG_LO, 32'h00008c50);
    send(4'h1, 4'h1);
    chk(q, 32'hc4);
    chk(len, 8'd88);
    rd_chk(`TELIAM_REG_RX_DIG_LO, 32'h00008c50);
    bad <= 1'b1;
    send(4'h1, 4'h1);
    chk(q, 32'h0c);
    rd_chk(`TELIAM_REG_RX_IAM, 32'h00040909);
    bad <= 1'b0;
    bus(1'b1, `TELIAM_REG_TX_DIG_LO, 32'h0000ea51);
    send(4'h1, 4'h1);
    chk(q, 32'he4);
    rd_chk(`TELIAM_REG_RX_DIG_LO, 32'h0000ea51);
    for (int i = 0; i < 9; i++) begin
      send(hd[i][3:0], hd[i][7:4]);
      chk(q[6:2], 5'h01);
      chk(len, 8'd48);
      bus(1'b0, `TELIAM_REG_RX_HEAD, 32'h0);
      chk(q[7:0], hd[i]);
    end
    for (int i = 0; i < 6; i++) begin
      send(ref_h[i][3:0], ref_h[i][7:4]);
      chk(q, 32'h2);
    end
    wrap_up;
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end
endmodule
`default_nettype wire
